// *** multifunction_mul_alu_decode.sv ***
// multifunction multiply/alu compute-field decoder
`timescale 1ns/10ps
module multifunction_mul_alu_decode
    import mfdec_pkg::*;
(
    input wire logic mclk,          // core clock, 25 MHz
    input wire logic srst,          // synchronous reset, active high
    input wire logic issue,         // compute field valid this cycle
    input wire logic [22:0] field,  // 23-bit compute field
    output dec_t dec,               // registered decode, one cycle later
    output mul_op_t mul_op,         // registered multiplier operation
    output alu_op_t alu_op,         // registered alu operation
    output logic undefined          // registered: issued but unassigned code
);
    // ****************************************
    // combinational decode
    // ****************************************
    dec_t dec_nxt;
    mul_op_t mul_nxt;
    alu_op_t alu_nxt;
    logic undef_nxt;
    dec_t dec_r;
    mul_op_t mul_r;
    alu_op_t alu_r;
    logic undef_r;
    logic [5:0] opc;
    logic [1:0] sub;

    assign opc = field[OPC_HI:OPC_LO];
    assign sub = opc[1:0];

    always_comb begin
        dec_nxt = '0;
        mul_nxt = MUL_NONE;
        alu_nxt = ALU_NONE;
        undef_nxt = 1'b0;
        // operand quartets fixed for every form, fixed or float
        dec_nxt.mx = {MX_BASE, field[MX_HI:MX_LO]};
        dec_nxt.my = {MY_BASE, field[MY_HI:MY_LO]};
        dec_nxt.ax = {AX_BASE, field[AX_HI:AX_LO]};
        dec_nxt.ay = {AY_BASE, field[AY_HI:AY_LO]};
        dec_nxt.mul_dst = field[DST_M_HI:DST_M_LO];
        dec_nxt.alu_dst = field[DST_S_HI:DST_S_LO];
        dec_nxt.diff_dst = field[DST_A_HI:DST_A_LO];
        if (issue && field[FORM_BIT]) begin
            if (field[DUAL_HI:DUAL_LO] == DUAL_FIX ||
                    field[DUAL_HI:DUAL_LO] == DUAL_FLT) begin
                dec_nxt.valid = 1'b1;
                dec_nxt.is_float = (field[DUAL_HI:DUAL_LO] == DUAL_FLT);
                dec_nxt.mul_dst_we = 1'b1;
                dec_nxt.alu_dst_we = 1'b1;
                dec_nxt.diff_dst_we = 1'b1;
                dec_nxt.alu_dst_fixed = !dec_nxt.is_float;
                mul_nxt = dec_nxt.is_float ? MUL_FLT : MUL_FIX_RND;
                alu_nxt = ALU_ADDSUB;
            end else if (opc >= OPC_FIX_FIRST && opc <= OPC_FIX_LAST
                    && sub != 2'h3) begin
                dec_nxt.valid = 1'b1;
                dec_nxt.alu_dst_we = 1'b1;
                dec_nxt.alu_dst_fixed = 1'b1;
                unique case (sub)
                    SUB_ALU_ADD: alu_nxt = ALU_ADD;
                    SUB_ALU_SUB: alu_nxt = ALU_SUB;
                    default: alu_nxt = ALU_AVG;
                endcase
                unique case (opc[5:2])
                    MUL_RND: begin
                        mul_nxt = MUL_FIX_RND;
                        dec_nxt.mul_dst_we = 1'b1;
                    end
                    MUL_ACC: begin
                        mul_nxt = MUL_FIX_ACC;
                        dec_nxt.acc_we = 1'b1;
                    end
                    MUL_ACC_RND: begin
                        mul_nxt = MUL_FIX_ACC_RND;
                        dec_nxt.mul_dst_we = 1'b1;
                    end
                    MUL_SUB: begin
                        mul_nxt = MUL_FIX_SUB;
                        dec_nxt.acc_we = 1'b1;
                    end
                    default: begin
                        mul_nxt = MUL_FIX_SUB_RND;
                        dec_nxt.mul_dst_we = 1'b1;
                    end
                endcase
            end else if (opc >= OPC_FLT_FIRST && opc <= OPC_FLT_LAST) begin
                dec_nxt.valid = 1'b1;
                dec_nxt.is_float = 1'b1;
                dec_nxt.mul_dst_we = 1'b1;
                dec_nxt.alu_dst_we = 1'b1;
                mul_nxt = MUL_FLT;
                unique case (opc)
                    OPC_FLT_ADD: alu_nxt = ALU_ADD;
                    OPC_FLT_SUB: alu_nxt = ALU_SUB;
                    OPC_FLT_AVG: alu_nxt = ALU_AVG;
                    OPC_FLT_CVT: alu_nxt = ALU_FLOAT;
                    OPC_FLT_FIX: begin
                        alu_nxt = ALU_FIX;
                        dec_nxt.alu_dst_fixed = 1'b1;
                    end
                    OPC_FLT_ABS: alu_nxt = ALU_ABS;
                    OPC_FLT_MAX: alu_nxt = ALU_MAX;
                    default: alu_nxt = ALU_MIN;
                endcase
            end else begin
                undef_nxt = 1'b1;
            end
        end
    end

    // ****************************************
    // output stage
    // ****************************************
    // one register stage for both halves: sources are named in the same
    // cycle and both write enables come out together, so neither half can
    // overwrite an operand the other still has to read
    always_ff @(posedge mclk) begin
        if (srst) begin
            dec_r <= '0;
            mul_r <= MUL_NONE;
            alu_r <= ALU_NONE;
            undef_r <= 1'b0;
        end else begin
            dec_r <= dec_nxt;
            mul_r <= mul_nxt;
            alu_r <= alu_nxt;
            undef_r <= undef_nxt;
        end
    end

    assign dec = dec_r;
    assign mul_op = mul_r;
    assign alu_op = alu_r;
    assign undefined = undef_r;
    // core registers are named by the field only; no address port exists
    // decode outputs are read-only status with no sticky bits, so there
    // is nothing here for a write to clear

    // ****************************************
    // assertions
    // ****************************************
    property p_quartet;
        @(posedge mclk) disable iff (srst)
        dec.valid |-> dec.mx[3:2] == MX_BASE && dec.my[3:2] == MY_BASE &&
            dec.ax[3:2] == AX_BASE && dec.ay[3:2] == AY_BASE;
    endproperty
    operand_quartet_a: assert property (p_quartet)
        else $error("operand outside its quartet");
    mx_select_a: assert property (@(posedge mclk) disable iff (srst)
        issue |=> dec.mx == {MX_BASE, $past(field[MX_HI:MX_LO])})
        else $error("multiplier x select wrong");
    ay_select_a: assert property (@(posedge mclk) disable iff (srst)
        issue |=> dec.ay == {AY_BASE, $past(field[AY_HI:AY_LO])})
        else $error("alu y select wrong");
    dual_fix_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:20] == 3'h6 |=> alu_op == ALU_ADDSUB && !dec.is_float
            && dec.diff_dst_we && dec.alu_dst_we)
        else $error("fixed dual form not decoded");
    dual_flt_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:20] == 3'h7 |=> mul_op == MUL_FLT && dec.is_float)
        else $error("float dual form not decoded");
    acc_only_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h12 && field[17:16] != 2'h3
            |=> dec.acc_we && !dec.mul_dst_we && mul_op == MUL_FIX_ACC)
        else $error("accumulate form wrote register");
    fix_conv_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5b |=> alu_op == ALU_FIX && dec.alu_dst_fixed)
        else $error("fix conversion dest wrong");
    undef_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        undefined |-> !dec.mul_dst_we && !dec.alu_dst_we && !dec.acc_we
            && !dec.diff_dst_we)
        else $error("undefined code wrote a destination");
    idle_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        !issue |=> !dec.valid && !undefined)
        else $error("decode without issue");

    // ****************************************
    // assertion helpers
    // ****************************************
    // field classes seen at the pins, kept apart from the decode above so
    // that a slip in the decoder cannot hide itself in its own checks
    logic dual_issue;  // issued field in one of the two dual forms
    logic tbl_issue;   // issued field that goes to the six-bit table
    assign dual_issue = issue && field[FORM_BIT] && field[DUAL_HI];
    assign tbl_issue = issue && field[FORM_BIT] && !field[DUAL_HI];

    // ****************************************
    // operand quartets
    // ****************************************
    my_select_a: assert property (@(posedge mclk) disable iff (srst)
        issue |=> dec.my == {MY_BASE, $past(field[MY_HI:MY_LO])})
        else $error("multiplier y select wrong");
    ax_select_a: assert property (@(posedge mclk) disable iff (srst)
        issue |=> dec.ax == {AX_BASE, $past(field[AX_HI:AX_LO])})
        else $error("alu x select wrong");
    flt_quartet_a: assert property (@(posedge mclk) disable iff (srst)
        dual_issue && field[DUAL_LO] |=> dec.is_float && dec.mx[3:2] == MX_BASE
            && dec.my[3:2] == MY_BASE && dec.ax[3:2] == AX_BASE
            && dec.ay[3:2] == AY_BASE)
        else $error("float form left its quartets");

    // ****************************************
    // dual forms
    // ****************************************
    dual_dest_a: assert property (@(posedge mclk) disable iff (srst)
        dual_issue |=> dec.diff_dst == $past(field[DST_A_HI:DST_A_LO])
            && dec.mul_dst == $past(field[DST_M_HI:DST_M_LO])
            && dec.alu_dst == $past(field[DST_S_HI:DST_S_LO]))
        else $error("dual form destinations wrong");
    dual_flt_we_a: assert property (@(posedge mclk) disable iff (srst)
        dual_issue && field[DUAL_LO] |=> dec.mul_dst_we && dec.alu_dst_we
            && dec.diff_dst_we && alu_op == ALU_ADDSUB && !dec.alu_dst_fixed)
        else $error("float dual form enables wrong");
    dual_first_a: assert property (@(posedge mclk) disable iff (srst)
        dual_issue |=> dec.valid && !undefined && !dec.acc_we)
        else $error("dual form fell into the code table");

    // ****************************************
    // fixed-point code table
    // ****************************************
    // codes 03 to 17 ending in 11 sit between or beside the fixed groups and must stay quiet
    table_split_a: assert property (@(posedge mclk) disable iff (srst)
        tbl_issue |=> dec.valid != undefined)
        else $error("table code both or neither defined");
    rnd_prod_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h11 && field[17:16] != 2'h3
            |=> mul_op == MUL_FIX_RND && dec.mul_dst_we && !dec.acc_we)
        else $error("rounded product form wrong");
    avg_alu_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h46 |=> alu_op == ALU_AVG && dec.alu_dst_fixed)
        else $error("halved sum not decoded");
    acc_sub_alu_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h49 |=> alu_op == ALU_SUB && dec.alu_dst_we)
        else $error("accumulate with difference wrong");
    acc_rnd_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h13 && field[17:16] != 2'h3
            |=> mul_op == MUL_FIX_ACC_RND && dec.mul_dst_we && !dec.acc_we)
        else $error("rounded accumulate form wrote accumulator");
    acc_rnd_add_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h4c |=> alu_op == ALU_ADD && dec.valid)
        else $error("rounded accumulate with sum wrong");
    acc_minus_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h14 && field[17:16] != 2'h3
            |=> mul_op == MUL_FIX_SUB && dec.acc_we && !dec.mul_dst_we)
        else $error("accumulator subtract wrote register");
    sub_rnd_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h15 && field[17:16] != 2'h3
            |=> mul_op == MUL_FIX_SUB_RND && dec.mul_dst_we && !dec.acc_we)
        else $error("rounded subtract form wrong");
    sub_rnd_avg_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h56 |=> alu_op == ALU_AVG && !dec.is_float)
        else $error("rounded subtract with halved sum wrong");
    hole_code_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:21] == 2'h2 && field[20:18] <= 3'h5 && field[17:16] == 2'h3
            |=> undefined && !dec.valid)
        else $error("code between groups was decoded");
    low_code_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:18] == 5'h10 |=> undefined && mul_op == MUL_NONE)
        else $error("code below the table was decoded");

    // ****************************************
    // floating-point code table
    // ****************************************
    flt_add_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h58 |=> mul_op == MUL_FLT && alu_op == ALU_ADD
            && dec.mul_dst_we && dec.alu_dst_we)
        else $error("float multiply with sum wrong");
    flt_sub_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h59 |=> alu_op == ALU_SUB && dec.is_float)
        else $error("float multiply with difference wrong");
    flt_avg_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5c |=> alu_op == ALU_AVG && !dec.alu_dst_fixed)
        else $error("float multiply with halved sum wrong");
    flt_side_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:19] == 4'hb |=> mul_op == MUL_FLT && !dec.diff_dst_we
            && !dec.acc_we && !undefined)
        else $error("float table form wrote a stray destination");
    float_conv_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5a |=> alu_op == ALU_FLOAT && !dec.alu_dst_fixed)
        else $error("float conversion dest wrong");
    flt_abs_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5d |=> alu_op == ALU_ABS && dec.is_float)
        else $error("absolute value form wrong");
    flt_max_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5e |=> alu_op == ALU_MAX && dec.is_float)
        else $error("maximum form wrong");
    flt_min_a: assert property (@(posedge mclk) disable iff (srst)
        issue && field[22:16] == 7'h5f |=> alu_op == ALU_MIN && dec.is_float)
        else $error("minimum form wrong");

    // ****************************************
    // both halves together
    // ****************************************
    // a multiply write never goes out without its alu partner, so the two
    // halves always retire in the same cycle
    halves_paired_a: assert property (@(posedge mclk) disable iff (srst)
        dec.alu_dst_we == (dec.mul_dst_we || dec.acc_we))
        else $error("multiply and alu halves split");

    // ****************************************
    // coverage
    // ****************************************
    cv_dual: cover property (@(posedge mclk) issue && field[22:21] == 2'h3);
    cv_acc: cover property (@(posedge mclk) mul_op == MUL_FIX_SUB);
    cv_min: cover property (@(posedge mclk) alu_op == ALU_MIN);
    cv_undef: cover property (@(posedge mclk) undefined);
    cv_fix: cover property (@(posedge mclk) alu_op == ALU_FIX && dec.alu_dst_fixed);
endmodule : multifunction_mul_alu_decode

// *** mfdec_pkg.sv ***
// package of constants and types for the multifunction compute-field decoder
// How it works
// - bit22 set, 21:20=10: fixed multiply, add, subtract
// - 21:20=11: float multiply, add, subtract
// - alu x operand is register 8 plus field
// - alu y operand is register 12 plus field
// - multiply x operand is register field value
// - multiply y operand is register 4 plus field
// - float forms use the same register quartets
// - six-bit code in 21:16 picks combined operation
// - codes 04-06: rounded product plus alu op
// - codes 08-0a: accumulate unrounded product, alu op
// - codes 0c-0e: rounded accumulator plus product
// - codes 10-12: subtract unrounded product from accumulator
// - codes 14-16: rounded accumulator minus product
// - codes 18,19,1c: float multiply, float alu op
// - codes 1a,1b: float multiply with float/fix conversion
// - codes 1d-1f: float multiply with abs, max, min
// - core registers reached only by instruction
// - control rw, status ro, sticky bits write-clear; here only read-only decode outputs, no control registers or sticky bits
package mfdec_pkg;
    // ****************************************
    // field positions
    // ****************************************
    localparam int FORM_BIT = 22;
    localparam int OPC_HI = 21;
    localparam int OPC_LO = 16;
    localparam int DUAL_HI = 21;
    localparam int DUAL_LO = 20;
    localparam int DST_A_HI = 19; // subtract dest in dual form
    localparam int DST_A_LO = 16;
    localparam int DST_M_HI = 15;
    localparam int DST_M_LO = 12;
    localparam int DST_S_HI = 11; // alu result / sum dest
    localparam int DST_S_LO = 8;
    localparam int MX_HI = 7;
    localparam int MX_LO = 6;
    localparam int MY_HI = 5;
    localparam int MY_LO = 4;
    localparam int AX_HI = 3;
    localparam int AX_LO = 2;
    localparam int AY_HI = 1;
    localparam int AY_LO = 0;
    // ****************************************
    // encodings and quartet bases
    // ****************************************
    localparam logic [1:0] DUAL_FIX = 2'h2;
    localparam logic [1:0] DUAL_FLT = 2'h3;
    localparam logic [1:0] MX_BASE = 2'h0;
    localparam logic [1:0] MY_BASE = 2'h1;
    localparam logic [1:0] AX_BASE = 2'h2;
    localparam logic [1:0] AY_BASE = 2'h3;
    localparam logic [5:0] OPC_FIX_FIRST = 6'h04;
    localparam logic [5:0] OPC_FIX_LAST = 6'h16;
    localparam logic [5:0] OPC_FLT_FIRST = 6'h18;
    localparam logic [5:0] OPC_FLT_LAST = 6'h1f;
    localparam logic [1:0] SUB_ALU_ADD = 2'h0;
    localparam logic [1:0] SUB_ALU_SUB = 2'h1;
    localparam logic [1:0] SUB_ALU_AVG = 2'h2;
    localparam logic [3:0] MUL_RND = 4'h1;
    localparam logic [3:0] MUL_ACC = 4'h2;
    localparam logic [3:0] MUL_ACC_RND = 4'h3;
    localparam logic [3:0] MUL_SUB = 4'h4;
    localparam logic [3:0] MUL_SUB_RND = 4'h5;
    localparam logic [5:0] OPC_FLT_ADD = 6'h18;
    localparam logic [5:0] OPC_FLT_SUB = 6'h19;
    localparam logic [5:0] OPC_FLT_CVT = 6'h1a;
    localparam logic [5:0] OPC_FLT_FIX = 6'h1b;
    localparam logic [5:0] OPC_FLT_AVG = 6'h1c;
    localparam logic [5:0] OPC_FLT_ABS = 6'h1d;
    localparam logic [5:0] OPC_FLT_MAX = 6'h1e;
    localparam logic [5:0] OPC_FLT_MIN = 6'h1f;

    typedef enum {
        MUL_NONE, MUL_FIX_RND, MUL_FIX_ACC, MUL_FIX_ACC_RND, MUL_FIX_SUB,
        MUL_FIX_SUB_RND, MUL_FLT
    } mul_op_t;

    typedef enum {
        ALU_NONE, ALU_ADD, ALU_SUB, ALU_AVG, ALU_ADDSUB, ALU_FLOAT, ALU_FIX,
        ALU_ABS, ALU_MAX, ALU_MIN
    } alu_op_t;

    typedef struct packed {
        logic valid;       // a defined multifunction form
        logic is_float;    // floating-point register view
        logic [3:0] mx;    // multiplier x register
        logic [3:0] my;    // multiplier y register
        logic [3:0] ax;    // alu x register
        logic [3:0] ay;    // alu y register
        logic [3:0] mul_dst;
        logic mul_dst_we;  // write product to register file
        logic acc_we;      // write foreground accumulator
        logic [3:0] alu_dst;
        logic alu_dst_we;
        logic alu_dst_fixed; // result lands in fixed-point view
        logic [3:0] diff_dst;
        logic diff_dst_we;
    } dec_t;
endpackage : mfdec_pkg

// *** tb.sv ***
// self-checking testbench for the multifunction compute-field decoder
`timescale 1ns/10ps
module tb;
import mfdec_pkg::*;
    // ****************************************
    // signals and expectation queue
    // ****************************************
    typedef struct {
        dec_t e;
        dec_t m;
        mul_op_t mo;
        alu_op_t ao;
        logic u;
        logic ck;
    } note_t;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic issue = 1'b0;
    logic [22:0] field = 23'h000000;
    logic [22:0] f;
    dec_t dec;
    mul_op_t mul_op;
    alu_op_t alu_op;
    logic undefined;
    int n_mismatch = 0;
    int check_count = 0;
    note_t q[$];
    note_t cur;
    alu_op_t flt_tab[8] = '{ALU_ADD, ALU_SUB, ALU_FLOAT, ALU_FIX, ALU_AVG, ALU_ABS, ALU_MAX,
        ALU_MIN};
    always #20 mclk = ~mclk;
    multifunction_mul_alu_decode multifunction_mul_alu_decode_i (.mclk(mclk), .srst(srst),
        .issue(issue), .field(field), .dec(dec), .mul_op(mul_op), .alu_op(alu_op),
        .undefined(undefined));
    // ****************************************
    // reference decode
    // ****************************************
    function automatic note_t model(input logic r, input logic iss, input logic [22:0] x);
        note_t n;
        dec_t k;
        logic [5:0] o;
        logic [2:0] g;
        k = '0;
        k.mx = '1;
        k.my = '1;
        k.ax = '1;
        k.ay = '1;
        k.mul_dst = '1;
        k.alu_dst = '1;
        k.diff_dst = '1;
        n.e = '0;
        n.m = '1;
        n.mo = MUL_NONE;
        n.ao = ALU_NONE;
        n.u = 1'b0;
        n.ck = 1'b1;
        o = x[21:16];
        g = o[4:2];
        if (r) return n;
        // register numbers only matter once a form is defined
        if (!iss) begin
            n.m = ~k;
            return n;
        end
        n.e.mx = {2'h0, x[7:6]};
        n.e.my = {2'h1, x[5:4]};
        n.e.ax = {2'h2, x[3:2]};
        n.e.ay = {2'h3, x[1:0]};
        n.e.mul_dst = x[15:12];
        n.e.alu_dst = x[11:8];
        n.e.diff_dst = x[19:16];
        if (!x[22]) begin
            n.m = ~k;
        end else if (x[21]) begin
            n.e.valid = 1'b1;
            n.e.is_float = x[20];
            n.mo = x[20] ? MUL_FLT : MUL_FIX_RND;
            n.ao = ALU_ADDSUB;
            n.e.mul_dst_we = 1'b1;
            n.e.alu_dst_we = 1'b1;
            n.e.diff_dst_we = 1'b1;
            n.e.alu_dst_fixed = ~x[20];
        end else if (g >= 3'h1 && g <= 3'h5 && o[1:0] != 2'h3) begin
            n.e.valid = 1'b1;
            n.mo = mul_op_t'(g);
            n.ao = alu_op_t'(o[1:0] + 2'h1);
            n.e.mul_dst_we = g[0];
            n.e.acc_we = ~g[0];
            n.e.alu_dst_we = 1'b1;
            n.e.alu_dst_fixed = 1'b1;
            n.m.diff_dst = '0;
        end else if (g >= 3'h6) begin
            n.e.valid = 1'b1;
            n.e.is_float = 1'b1;
            n.mo = MUL_FLT;
            n.ao = flt_tab[o[2:0]];
            n.e.mul_dst_we = 1'b1;
            n.e.alu_dst_we = 1'b1;
            n.e.alu_dst_fixed = (o[2:0] == 3'h3);
            n.m.diff_dst = '0;
        end else begin
            n.u = 1'b1;
            n.m = ~k;
        end
        return n;
    endfunction : model
    // ****************************************
    // driver, compare tasks and monitor
    // ****************************************
    task automatic step(input logic r, input logic iss, input logic [22:0] x);
        @(negedge mclk);
        srst = r;
        issue = iss;
        field = x;
        q.push_back(model(r, iss, x));
    endtask : step
    task automatic cmp_dec(input dec_t e, input dec_t m, input dec_t got);
        check_count++;
        if ((got & m) !== (e & m)) begin
            n_mismatch++;
            $display("CHECK FAILED dec expected %h seen %h", e & m, got & m);
        end
    endtask : cmp_dec
    task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] got);
        check_count++;
        if (got !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
        end
    endtask : cmp_word
    always @(posedge mclk) begin
        #1;
        if (q.size() > 0) begin
            cur = q.pop_front();
            cmp_dec(cur.e, cur.m, dec);
            cmp_word("undefined", {31'h0, cur.u}, {31'h0, undefined});
            if (cur.ck) cmp_word("mul_op", cur.mo, mul_op);
            if (cur.ck) cmp_word("alu_op", cur.ao, alu_op);
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        void'($urandom(20740));
        // nothing but zeros is driven while the decoder is held in reset
        repeat (8) step(1'b1, 1'b0, 23'h000000);
        $display("test reset done");
        // back-to-back dual forms, both number formats
        for (int i = 0; i < 32; i++) begin
            f = 23'($urandom());
            f[22:20] = {2'h3, i[0]};
            step(1'b0, 1'b1, f);
        end
        $display("test dual forms done");
        // every code of the six-bit table, twice with fresh operands
        for (int i = 0; i < 128; i++) begin
            f = 23'($urandom());
            f[22:16] = {1'b1, i[5:0]};
            step(1'b0, 1'b1, f);
        end
        $display("test opcode sweep done");
        // other formats and idle cycles must leave all enables low; every fourth cycle issues a random compute field
        for (int i = 0; i < 40; i++) begin
            f = 23'($urandom());
            f[22] = i[1];
            step(1'b0, i[0], f);
        end
        $display("test idle and foreign formats done");
        step(1'b0, 1'b1, 23'h6abcde);
        step(1'b1, 1'b1, 23'h6abcde);
        step(1'b0, 1'b1, 23'h441234);
        step(1'b0, 1'b0, 23'h441234);
        $display("test mid-run reset done");
        for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge mclk);
        #2;
        if (q.size() > 0) n_mismatch++;
        print_verdict;
    end
endmodule : tb
